/* dv/cfr_alu_model.sv */
module cfr_alu_model (
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic go,
    input wire logic wide,
    output cfr_pkg::cfr_alu_upd_t upd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] sum;
    logic [4:0] low;
    assign sum = {1'b0, a} + {1'b0, b};
    assign low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    // Wide results model a pair move: no carries
    always_comb
    begin
        upd = '0;
        upd.en = go;
        upd.wide = wide;
        upd.result = wide ? {a, b} : {8'h00, sum[7:0]};
        upd.c = !wide && sum[8];
        upd.h = !wide && low[4];
        upd.v = !wide && (a[7] == b[7]) && (sum[7] != a[7]);
        {upd.upd_h, upd.upd_v, upd.upd_n, upd.upd_z, upd.upd_c} = 5'h1f;
    end
endmodule : cfr_alu_model

/* dv/cfr_core_state_asserts.sv */
module cfr_core_state_asserts #(
    parameter logic [cfr_pkg::STK_W-1:0] LAST_RAM_ADDRESS = cfr_pkg::LAST_RAM_ADDRESS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input cfr_pkg::cfr_acc_t acc,
    input cfr_pkg::cfr_alu_upd_t alu_upd,
    input wire logic set_gie,
    input wire logic clr_gie,
    input wire logic int_enter,
    input wire logic interrupt_return_op,
    input wire logic sub_call,
    input wire logic sub_return,
    input wire logic push_byte,
    input wire logic pop_byte,
    input wire logic int_grant_q,
    input wire logic [7:0] acc_rdata_q,
    input wire logic acc_hit_q,
    input wire logic [7:0] processor_flags_q,
    input wire logic [cfr_pkg::STK_W-1:0] stack_top_pointer_q
);
    wire logic [7:0] f = processor_flags_q;
    wire logic [10:0] sp = stack_top_pointer_q;
    // A stack load or wider step outranks byte steps
    wire logic quiet = !(acc.wr | sub_call | int_enter | sub_return | interrupt_return_op);

    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    chk_sign_xor: assert property (f[4] == (f[2] ^ f[3]))
        else $error("Sign flag differs");
    chk_reset_vals: assert property ($rose(rst_n) |-> f == 8'h00 && sp == LAST_RAM_ADDRESS)
        else $error("Reset state wrong");
    chk_gie_gate: assert property (!f[7] && !set_gie && !interrupt_return_op |=> !int_grant_q)
        else $error("Grant without enable");
    chk_enter_clear: assert property (int_enter |=> !f[7])
        else $error("Enable kept on entry");
    chk_return_set: assert property (interrupt_return_op && !clr_gie && !int_enter |=> f[7])
        else $error("Enable not set on return");
    chk_call_step: assert property ((sub_call || int_enter) && !acc.wr |=> sp == $past(sp) - 11'h002)
        else $error("Call step wrong");
    chk_ret_step: assert property ((sub_return || interrupt_return_op) && !acc.wr && !sub_call && !int_enter
        |=> sp == $past(sp) + 11'h002)
        else $error("Return step wrong");
    chk_push_step: assert property (push_byte && quiet |=> sp == $past(sp) - 11'h001)
        else $error("Push step wrong");
    chk_pop_step: assert property (pop_byte && quiet && !push_byte |=> sp == $past(sp) + 11'h001)
        else $error("Pop step wrong");
    chk_zero_flag: assert property (alu_upd.en && alu_upd.upd_z && !alu_upd.wide
        |=> f[1] == ($past(alu_upd.result[7:0]) == 8'h00))
        else $error("Zero flag wrong");
    chk_high_read: assert property (acc.rd && !acc.io_space && acc.addr == 16'h005e
        |=> acc_hit_q && acc_rdata_q[7:3] == 5'h00)
        else $error("High stack byte bits set");
    chk_unmapped_gap: assert property (acc.rd && !acc.io_space && acc.addr inside {[16'h0020:16'h005c]}
        |=> !acc_hit_q && acc_rdata_q == 8'h00)
        else $error("Gap address answered");
endmodule : cfr_core_state_asserts

bind cfr_core_state cfr_core_state_asserts #(.LAST_RAM_ADDRESS(LAST_RAM_ADDRESS)) i_chk (.core_clk, .rst_n,
    .acc, .alu_upd, .set_gie, .clr_gie, .int_enter, .interrupt_return_op, .sub_call, .sub_return,
    .push_byte, .pop_byte, .int_grant_q, .acc_rdata_q, .acc_hit_q, .processor_flags_q, .stack_top_pointer_q);

/* dv/tb_cfr_core_state.sv */
module tb_cfr_core_state;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [10:0] LR = 11'h5a3;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    cfr_pkg::cfr_acc_t acc = '0;
    cfr_pkg::cfr_wr8_t wr8 = '0;
    cfr_pkg::cfr_wr16_t wr16 = '0;
    cfr_pkg::cfr_bit_op_t bit_op = '0;
    cfr_pkg::cfr_ptr_req_t ptr_req = '0;
    cfr_pkg::cfr_alu_upd_t alu_upd;
    logic [7:0] a = 8'h00;
    logic [7:0] b = 8'h00;
    logic go = 1'b0;
    logic wide = 1'b0;
    logic [7:0] pulse = 8'h00;
    logic int_req = 1'b0;
    logic [7:0] acc_rdata_q;
    logic acc_hit_q;
    logic [4:0] ra = 5'h1e;
    logic [4:0] rb = 5'h00;
    logic [3:0] rw = 4'hf;
    logic [7:0] rd_a_q;
    logic [7:0] rd_b_q;
    logic [15:0] rd_w_q;
    logic [15:0] ptr_addr_q;
    logic ptr_valid_q;
    logic int_grant_q;
    logic rd_d1 = 1'b0;
    logic [9:0] exp_q[$];
    logic [9:0] e;
    logic [47:0] pq[$];
    logic [47:0] pn;
    logic [15:0] pe;
    logic [8:0] s;
    logic [4:0] l;
    logic [7:0] ef;
    logic [7:0] x;
    logic [7:0] y;
    logic [10:0] sp;
    logic [15:0] z;
    logic wd;
    logic [7:0] op[5] = '{8'h40, 8'h10, 8'h80, 8'h20, 8'h04};
    logic [10:0] dl[5] = '{11'h7ff, 11'h7fe, 11'h001, 11'h002, 11'h7fe};
    logic [7:0] gp[4] = '{8'h01, 8'h04, 8'h08, 8'h02};
    cfr_pkg::cfr_ptr_mode_t pm[5] = '{cfr_pkg::PTR_POSTINC, cfr_pkg::PTR_PREDEC, cfr_pkg::PTR_DISP,
        cfr_pkg::PTR_PREDEC, cfr_pkg::PTR_PLAIN};
    logic [15:0] pd[5] = '{16'h0001, 16'hffff, 16'h0000, 16'hffff, 16'h0000};
    int failures = 0;
    int n_compared = 0;

    always #2.5 core_clk = ~core_clk;

    cfr_alu_model i_alu (.a, .b, .go, .wide, .upd(alu_upd));

    cfr_core_state #(.LAST_RAM_ADDRESS(LR)) i_dut (.core_clk, .rst_n, .rd_a_addr(ra), .rd_b_addr(rb),
        .rd_w_pair(rw), .rd_a_q, .rd_b_q, .rd_w_q, .wr8, .wr16, .alu_upd, .bit_op, .ptr_req,
        .ptr_addr_q, .ptr_valid_q, .acc, .acc_rdata_q, .acc_hit_q, .set_gie(pulse[0]), .clr_gie(pulse[1]),
        .int_enter(pulse[2]), .interrupt_return_op(pulse[3]), .sub_call(pulse[4]), .sub_return(pulse[5]),
        .push_byte(pulse[6]), .pop_byte(pulse[7]), .int_req, .int_grant_q, .processor_flags_q(),
        .stack_top_pointer_q());

    task automatic complete_run;
        if (failures == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    task automatic bus(input logic w, input logic io, input logic [15:0] ad, input logic [7:0] d,
        input logic [8:0] ex);
        @(posedge core_clk);
        acc <= '{rd: !w, wr: w, io_space: io, addr: ad, wdata: d};
        if (!w)
            exp_q.push_back({int_req && ef[7], ex});
        @(posedge core_clk);
        acc <= '0;
    endtask : bus

    task automatic pl(input logic [7:0] p);
        @(posedge core_clk);
        pulse <= p;
        @(posedge core_clk);
        pulse <= 8'h00;
    endtask : pl

    always @(posedge core_clk)
        rd_d1 <= acc.rd;

    // Read answers land one cycle after the request
    always @(negedge core_clk)
    begin
        if (rd_d1)
        begin
            e = exp_q.pop_front();
            n_compared++;
            if ({int_grant_q, acc_hit_q, acc_rdata_q} !== e)
            begin
                failures++;
                $display("Error at %0t: read got %h expected %h", $time, {int_grant_q, acc_hit_q, acc_rdata_q}, e);
            end
        end
        if (ptr_valid_q)
        begin
            pn = pq.pop_front();
            n_compared++;
            if ({ptr_addr_q, rd_a_q, rd_b_q, rd_w_q} !== pn)
            begin
                failures++;
                $display("Error at %0t: ports got %h expected %h", $time, {ptr_addr_q, rd_a_q, rd_b_q, rd_w_q}, pn);
            end
        end
    end

    initial
    begin
        #10us;
        failures++;
        complete_run;
    end

    initial
    begin
        void'($urandom(32'h55b8));
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        bus(0, 0, 16'h005f, 0, 9'h100);
        bus(0, 0, 16'h005d, 0, {1'b1, LR[7:0]});
        bus(0, 0, 16'h005e, 0, {6'h20, LR[10:8]});
        bus(0, 1, 16'h003e, 0, {6'h20, LR[10:8]});
        bus(0, 0, 16'h0040, 0, 9'h000);
        bus(1, 0, 16'h005e, 8'hfb, 0);
        bus(0, 0, 16'h005e, 0, 9'h103);
        bus(1, 1, 16'h003d, 8'h01, 0);
        sp = 11'h301;
        foreach (op[i])
        begin
            pl(op[i]);
            sp = sp + dl[i];
            bus(0, 0, 16'h005d, 0, {1'b1, sp[7:0]});
        end
        bus(0, 0, 16'h005e, 0, {6'h20, sp[10:8]});
        bus(1, 0, 16'h005f, 8'h7f, 0);
        ef = 8'h6f;
        bus(0, 0, 16'h005f, 0, {1'b1, ef});
        int_req <= 1'b1;
        foreach (gp[i])
        begin
            pl(gp[i]);
            ef[7] = ~i[0];
            bus(0, 0, 16'h005f, 0, {1'b1, ef});
        end
        for (int i = 0; i < 10; i++)
        begin
            x = (i == 0) ? 8'h80 : (i == 8) ? 8'h01 : (i == 9) ? 8'h00 : 8'($urandom);
            y = (i == 0) ? 8'h80 : (i >= 8) ? 8'h00 : 8'($urandom);
            wd = i >= 8;
            s = {1'b0, x} + {1'b0, y};
            l = {1'b0, x[3:0]} + {1'b0, y[3:0]};
            if (wd)
                ef[5:0] = {1'b0, x[7], 1'b0, x[7], {x, y} == 16'h0000, 1'b0};
            else
                ef[5:0] = {l[4], s[7] ^ (x[7] == y[7] && s[7] != x[7]), x[7] == y[7] && s[7] != x[7],
                    s[7], s[7:0] == 8'h00, s[8]};
            @(posedge core_clk);
            a <= x;
            b <= y;
            wide <= wd;
            go <= 1'b1;
            @(posedge core_clk);
            go <= 1'b0;
            bus(0, 0, 16'h005f, 0, {1'b1, ef});
        end
        @(posedge core_clk);
        wr8 <= '{en: 1'b1, addr: 5'd5, data: 8'h7f};
        @(posedge core_clk);
        wr8 <= '0;
        bit_op <= '{store: 1'b1, load: 1'b0, addr: 5'd5, sel: 3'd7};
        @(posedge core_clk);
        bit_op <= '{store: 1'b0, load: 1'b1, addr: 5'd5, sel: 3'd0};
        @(posedge core_clk);
        bit_op <= '0;
        // Copy flag was one, so storing a zero and loading it back both show
        ef[6] = 1'b0;
        bus(0, 0, 16'h005f, 0, {1'b1, ef});
        bus(0, 0, 16'h0006, 0, 9'h100);
        bus(0, 0, 16'h0005, 0, 9'h17e);
        bus(1, 0, 16'h0003, 8'ha5, 0);
        bus(0, 0, 16'h0003, 0, 9'h1a5);
        @(posedge core_clk);
        wr16 <= '{en: 1'b1, pair: 4'hf, data: 16'h12ff};
        @(posedge core_clk);
        wr16 <= '0;
        z = 16'h12ff;
        bus(0, 0, 16'h001e, 0, 9'h1ff);
        foreach (pm[i])
        begin
            @(posedge core_clk);
            ptr_req <= '{en: 1'b1, sel: 2'd2, mode: pm[i], disp: 6'h3f};
            ra <= i[0] ? 5'h1f : 5'h1e;
            rb <= 5'(i);
            rw <= i[0] ? 4'h1 : 4'hf;
            pe = (pm[i] == cfr_pkg::PTR_DISP) ? z + 16'h003f : (pm[i] == cfr_pkg::PTR_PREDEC) ? z - 16'h0001 : z;
            // Read ports show the pair before its own write-back
            pq.push_back({pe, i[0] ? z[15:8] : z[7:0], (i == 3) ? 8'ha5 : 8'h00, i[0] ? 16'ha500 : z});
            @(posedge core_clk);
            ptr_req <= '0;
            z = z + pd[i];
            bus(0, 0, 16'h001e, 0, {1'b1, z[7:0]});
            bus(0, 0, 16'h001f, 0, {1'b1, z[15:8]});
        end
        repeat (2) @(posedge core_clk);
        complete_run;
    end
endmodule : tb_cfr_core_state

/* logic/cfr_core_state.sv */
module cfr_core_state #(
    parameter logic [cfr_pkg::STK_W-1:0] LAST_RAM_ADDRESS = cfr_pkg::LAST_RAM_ADDRESS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [cfr_pkg::GPR_AW-1:0] rd_a_addr,
    input wire logic [cfr_pkg::GPR_AW-1:0] rd_b_addr,
    input wire logic [cfr_pkg::GPR_AW-2:0] rd_w_pair,
    output logic [7:0] rd_a_q,
    output logic [7:0] rd_b_q,
    output logic [15:0] rd_w_q,
    input cfr_pkg::cfr_wr8_t wr8,
    input cfr_pkg::cfr_wr16_t wr16,
    input cfr_pkg::cfr_alu_upd_t alu_upd,
    input cfr_pkg::cfr_bit_op_t bit_op,
    input cfr_pkg::cfr_ptr_req_t ptr_req,
    output logic [15:0] ptr_addr_q,
    output logic ptr_valid_q,
    input cfr_pkg::cfr_acc_t acc,
    output logic [7:0] acc_rdata_q,
    output logic acc_hit_q,
    input wire logic set_gie,
    input wire logic clr_gie,
    input wire logic int_enter,
    input wire logic interrupt_return_op,
    input wire logic sub_call,
    input wire logic sub_return,
    input wire logic push_byte,
    input wire logic pop_byte,
    input wire logic int_req,
    output logic int_grant_q,
    output logic [7:0] processor_flags_q,
    output logic [cfr_pkg::STK_W-1:0] stack_top_pointer_q
);

    logic [cfr_pkg::GPR_COUNT-1:0][7:0] gpr;
    logic [15:0] acc_addr;
    logic acc_is_gpr;
    logic hit_low;
    logic hit_high;
    logic hit_flags;
    logic [7:0] acc_read_val;
    logic bit_val;
    logic [7:0] bit_load_val;
    logic w8_en;
    logic [cfr_pkg::GPR_AW-1:0] w8_addr;
    logic [7:0] w8_data;
    logic w16_en;
    logic [cfr_pkg::GPR_AW-2:0] w16_pair;
    logic [15:0] w16_data;
    logic [cfr_pkg::GPR_AW-2:0] ptr_pair;
    logic [15:0] ptr_val;
    logic [15:0] ptr_next;
    logic [15:0] ptr_eff;
    logic ptr_wb;
    logic [7:0] processor_flags_d;
    logic alu_neg;
    logic alu_zero;
    cfr_pkg::cfr_stk_op_t stk_op;

    // Address decode; I/O space is folded onto data space
    always_comb
    begin
        if (acc.io_space)
        begin
            acc_addr = {10'h000, acc.addr[5:0]} + cfr_pkg::IO_TO_DS_OFS;
        end
        else
        begin
            acc_addr = acc.addr;
        end
    end

    assign acc_is_gpr = (acc_addr <= cfr_pkg::GPR_LAST_ADDR);
    assign hit_low = (acc_addr == cfr_pkg::STACK_LOW_ADDR);
    assign hit_high = (acc_addr == cfr_pkg::STACK_HIGH_ADDR);
    assign hit_flags = (acc_addr == cfr_pkg::FLAGS_ADDR);

    always_comb
    begin
        acc_read_val = 8'h00;
        if (acc_is_gpr)
        begin
            acc_read_val = gpr[acc_addr[cfr_pkg::GPR_AW-1:0]];
        end
        else if (hit_low)
        begin
            acc_read_val = stack_top_pointer_q[7:0];
        end
        else if (hit_high)
        begin
            acc_read_val = {5'h00, stack_top_pointer_q[cfr_pkg::STK_W-1:8]};
        end
        else if (hit_flags)
        begin
            acc_read_val = processor_flags_q;
        end
    end

    // Bit copy between a register and the copy-storage flag
    assign bit_val = gpr[bit_op.addr][bit_op.sel];

    always_comb
    begin
        bit_load_val = gpr[bit_op.addr];
        bit_load_val[bit_op.sel] = processor_flags_q[cfr_pkg::FLAG_T];
    end

    // Single 8-bit write port: result write first, then bit load, then data space
    always_comb
    begin
        w8_en = 1'b0;
        w8_addr = wr8.addr;
        w8_data = wr8.data;
        if (wr8.en)
        begin
            w8_en = 1'b1;
        end
        else if (bit_op.load)
        begin
            w8_en = 1'b1;
            w8_addr = bit_op.addr;
            w8_data = bit_load_val;
        end
        else if (acc.wr && acc_is_gpr)
        begin
            w8_en = 1'b1;
            w8_addr = acc_addr[cfr_pkg::GPR_AW-1:0];
            w8_data = acc.wdata;
        end
    end

    // Pointer pairs and their addressing modes
    assign ptr_pair = cfr_pkg::PTR_BASE_PAIR + {2'b00, ptr_req.sel};
    assign ptr_val = {gpr[{ptr_pair, 1'b1}], gpr[{ptr_pair, 1'b0}]};

    always_comb
    begin
        ptr_next = ptr_val;
        ptr_eff = ptr_val;
        ptr_wb = 1'b0;
        case (ptr_req.mode)
            cfr_pkg::PTR_POSTINC:
            begin
                ptr_next = ptr_val + 16'h0001;
                ptr_wb = ptr_req.en;
            end
            cfr_pkg::PTR_PREDEC:
            begin
                ptr_next = ptr_val - 16'h0001;
                ptr_eff = ptr_next;
                ptr_wb = ptr_req.en;
            end
            cfr_pkg::PTR_DISP:
            begin
                ptr_eff = ptr_val + {10'h000, ptr_req.disp};
            end
            default:
            begin
                ptr_eff = ptr_val;
            end
        endcase
    end

    // Pointer write-back owns the 16-bit port in its cycle
    always_comb
    begin
        if (ptr_wb)
        begin
            w16_en = 1'b1;
            w16_pair = ptr_pair;
            w16_data = ptr_next;
        end
        else
        begin
            w16_en = wr16.en;
            w16_pair = wr16.pair;
            w16_data = wr16.data;
        end
    end

    cfr_gpr_file #(
        .COUNT(cfr_pkg::GPR_COUNT),
        .AW(cfr_pkg::GPR_AW)
    ) u_gpr (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .we8(w8_en),
        .wa8(w8_addr),
        .wd8(w8_data),
        .we16(w16_en),
        .wa16(w16_pair),
        .wd16(w16_data),
        .regs_q(gpr)
    );

    // Read ports show the value before any write in the same cycle
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_a_q <= 8'h00;
            rd_b_q <= 8'h00;
            rd_w_q <= 16'h0000;
        end
        else
        begin
            rd_a_q <= gpr[rd_a_addr];
            rd_b_q <= gpr[rd_b_addr];
            rd_w_q <= {gpr[{rd_w_pair, 1'b1}], gpr[{rd_w_pair, 1'b0}]};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ptr_addr_q <= 16'h0000;
            ptr_valid_q <= 1'b0;
        end
        else
        begin
            ptr_addr_q <= ptr_eff;
            ptr_valid_q <= ptr_req.en;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_rdata_q <= 8'h00;
            acc_hit_q <= 1'b0;
        end
        else
        begin
            acc_rdata_q <= acc.rd ? acc_read_val : 8'h00;
            acc_hit_q <= acc.rd && (acc_is_gpr || hit_low || hit_high || hit_flags);
        end
    end

    // Flags
    assign alu_neg = alu_upd.wide ? alu_upd.result[15] : alu_upd.result[7];
    assign alu_zero = alu_upd.wide ? (alu_upd.result == 16'h0000) : (alu_upd.result[7:0] == 8'h00);

    always_comb
    begin
        processor_flags_d = processor_flags_q;
        if (acc.wr && hit_flags)
        begin
            processor_flags_d = acc.wdata;
        end
        if (alu_upd.en)
        begin
            if (alu_upd.upd_h)
            begin
                processor_flags_d[cfr_pkg::FLAG_H] = alu_upd.h;
            end
            if (alu_upd.upd_v)
            begin
                processor_flags_d[cfr_pkg::FLAG_V] = alu_upd.v;
            end
            if (alu_upd.upd_n)
            begin
                processor_flags_d[cfr_pkg::FLAG_N] = alu_neg;
            end
            if (alu_upd.upd_z)
            begin
                processor_flags_d[cfr_pkg::FLAG_Z] = alu_zero;
            end
            if (alu_upd.upd_c)
            begin
                processor_flags_d[cfr_pkg::FLAG_C] = alu_upd.c;
            end
        end
        if (bit_op.store)
        begin
            processor_flags_d[cfr_pkg::FLAG_T] = bit_val;
        end
        if (set_gie || interrupt_return_op)
        begin
            processor_flags_d[cfr_pkg::FLAG_I] = 1'b1;
        end
        // Clear beats set so an entry never leaves interrupts open
        if (clr_gie || int_enter)
        begin
            processor_flags_d[cfr_pkg::FLAG_I] = 1'b0;
        end
        // Written values cannot break the sign relation either
        processor_flags_d[cfr_pkg::FLAG_S] =
            processor_flags_d[cfr_pkg::FLAG_N] ^ processor_flags_d[cfr_pkg::FLAG_V];
    end

    // Entry and return touch only the enable bit; the rest stays as software left it
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            processor_flags_q <= cfr_pkg::FLAGS_RST;
        end
        else
        begin
            processor_flags_q <= processor_flags_d;
        end
    end

    // A clear in the same cycle already blocks the grant
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            int_grant_q <= 1'b0;
        end
        else
        begin
            int_grant_q <= int_req && processor_flags_q[cfr_pkg::FLAG_I] && !clr_gie && !int_enter;
        end
    end

    // Stack pointer steps
    always_comb
    begin
        if (int_enter || sub_call)
        begin
            stk_op = cfr_pkg::STK_PUSH2;
        end
        else if (interrupt_return_op || sub_return)
        begin
            stk_op = cfr_pkg::STK_POP2;
        end
        else if (push_byte)
        begin
            stk_op = cfr_pkg::STK_PUSH1;
        end
        else if (pop_byte)
        begin
            stk_op = cfr_pkg::STK_POP1;
        end
        else
        begin
            stk_op = cfr_pkg::STK_HOLD;
        end
    end

    cfr_stack_top #(
        .RESET_VALUE(LAST_RAM_ADDRESS)
    ) u_stack (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ld_low(acc.wr && hit_low),
        .ld_high(acc.wr && hit_high),
        .ld_data(acc.wdata),
        .op(stk_op),
        .ptr_q(stack_top_pointer_q)
    );

endmodule : cfr_core_state

/* logic/cfr_gpr_file.sv */
module cfr_gpr_file #(
    parameter int COUNT = cfr_pkg::GPR_COUNT,
    parameter int AW = cfr_pkg::GPR_AW
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic we8,
    input wire logic [AW-1:0] wa8,
    input wire logic [7:0] wd8,
    input wire logic we16,
    input wire logic [AW-2:0] wa16,
    input wire logic [15:0] wd16,
    output logic [COUNT-1:0][7:0] regs_q
);

    for (genvar i = 0; i < COUNT; i++)
    begin : g_entry
        localparam logic [AW-1:0] IDX = AW'(i);
        always_ff @(posedge core_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                regs_q[i] <= cfr_pkg::GPR_RST;
            end
            else if (we16 && wa16 == IDX[AW-1:1])
            begin
                regs_q[i] <= IDX[0] ? wd16[15:8] : wd16[7:0];
            end
            else if (we8 && wa8 == IDX)
            begin
                regs_q[i] <= wd8;
            end
        end
    end

endmodule : cfr_gpr_file

/* logic/cfr_pkg.sv */
package cfr_pkg;

    localparam int GPR_COUNT = 32;
    localparam int GPR_AW = 5;
    localparam int STK_W = 11;

    // Core register map in data space; I/O space sits 0x20 lower
    localparam logic [15:0] IO_TO_DS_OFS = 16'h0020;
    localparam logic [15:0] GPR_LAST_ADDR = 16'h001f;
    localparam logic [15:0] STACK_LOW_ADDR = 16'h005d;
    localparam logic [15:0] STACK_HIGH_ADDR = 16'h005e;
    localparam logic [15:0] FLAGS_ADDR = 16'h005f;

    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] GPR_RST = 8'h00;
    localparam int FLAG_I = 7;
    localparam int FLAG_T = 6;
    localparam int FLAG_H = 5;
    localparam int FLAG_S = 4;
    localparam int FLAG_V = 3;
    localparam int FLAG_N = 2;
    localparam int FLAG_Z = 1;
    localparam int FLAG_C = 0;

    // Arbitrary default; the real figure depends on the SRAM fitted
    localparam logic [STK_W-1:0] LAST_RAM_ADDRESS = 11'h7ff;
    localparam logic [STK_W-1:0] STK_STEP_BYTE = 11'h001;
    localparam logic [STK_W-1:0] STK_STEP_RETURN = 11'h002;
    localparam int STK_HIGH_BITS = 3;

    // Pairs 13, 14, 15 hold the three pointers (registers 26..31)
    localparam logic [3:0] PTR_BASE_PAIR = 4'hd;

    typedef enum logic [2:0] {STK_HOLD, STK_PUSH1, STK_POP1, STK_PUSH2, STK_POP2} cfr_stk_op_t;
    typedef enum logic [1:0] {PTR_PLAIN, PTR_POSTINC, PTR_PREDEC, PTR_DISP} cfr_ptr_mode_t;

    typedef struct packed {logic en; logic [GPR_AW-1:0] addr; logic [7:0] data;} cfr_wr8_t;
    typedef struct packed {logic en; logic [GPR_AW-2:0] pair; logic [15:0] data;} cfr_wr16_t;
    typedef struct packed {
        logic en; logic wide; logic [15:0] result; logic c; logic h; logic v;
        logic upd_h; logic upd_v; logic upd_n; logic upd_z; logic upd_c;
    } cfr_alu_upd_t;
    typedef struct packed {logic store; logic load; logic [GPR_AW-1:0] addr; logic [2:0] sel;} cfr_bit_op_t;
    typedef struct packed {logic en; logic [1:0] sel; cfr_ptr_mode_t mode; logic [5:0] disp;} cfr_ptr_req_t;
    typedef struct packed {logic rd; logic wr; logic io_space; logic [15:0] addr; logic [7:0] wdata;} cfr_acc_t;

endpackage : cfr_pkg

/* logic/cfr_stack_top.sv */
module cfr_stack_top #(
    parameter logic [cfr_pkg::STK_W-1:0] RESET_VALUE = cfr_pkg::LAST_RAM_ADDRESS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ld_low,
    input wire logic ld_high,
    input wire logic [7:0] ld_data,
    input cfr_pkg::cfr_stk_op_t op,
    output logic [cfr_pkg::STK_W-1:0] ptr_q
);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ptr_q <= RESET_VALUE;
        end
        else if (ld_low)
        begin
            ptr_q[7:0] <= ld_data;
        end
        else if (ld_high)
        begin
            ptr_q[cfr_pkg::STK_W-1:8] <= ld_data[cfr_pkg::STK_HIGH_BITS-1:0];
        end
        else
        begin
            // Downward growth: pushes lower the pointer
            case (op)
                cfr_pkg::STK_PUSH1: ptr_q <= ptr_q - cfr_pkg::STK_STEP_BYTE;
                cfr_pkg::STK_POP1: ptr_q <= ptr_q + cfr_pkg::STK_STEP_BYTE;
                cfr_pkg::STK_PUSH2: ptr_q <= ptr_q - cfr_pkg::STK_STEP_RETURN;
                cfr_pkg::STK_POP2: ptr_q <= ptr_q + cfr_pkg::STK_STEP_RETURN;
                default: ptr_q <= ptr_q;
            endcase
        end
    end

endmodule : cfr_stack_top
